// >>> design/sq_adc_seq.sv
// sar converter control: clock budget, reference select, sample-and-hold timing,
// multi-channel sequencer, per-channel results, limit check, result fifo
// assumes a comparator on cmp_in that is valid one conversion tick after dac_code changes,
// and a register master that keeps to one-cycle strobes
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sq_consts.svh"

module sq_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
      if (pop) rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  // storage needs no reset; reads are gated by out_valid
  always_ff @(posedge sys_clk) begin
    if (push) mem_ff[wp_ff] <= in_data;
  end
endmodule : sq_fifo

// Summary of operation
// RQ1: conversion clock never exceeds 18 MHz
// RQ2: conversion spans at least 18 conversion clocks
// RQ3: reference chooses supply, half, bandgap, external
// RQ4: sample aperture length is software programmable
// RQ5: eight channels, extendable to sixteen
// RQ6: scan steps enabled channels with no gaps
// RQ7: channel chosen by sequencer or by firmware
// RQ8: one result register per channel
// RQ9: each channel applies its own sample time
// RQ10: low/high limits raise out-of-range interrupt
// RQ11: out-of-range flagged right at conversion end; here set when the result enters the fifo, so a full fifo delays it
// RQ12: temperature sensor converts like any channel
// RQ13: low-power modes stop converter and sequencer
// RQ14: sequencer drives the analog input switches
// RQ15: temperature sensor bias can be switched off
// RQ16: range flags sticky, per-channel limit enables
// RQ17: scan end signals done, then stop/restart
module sq_adc_seq
  import sq_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [`SQ_AW-1:0]    reg_addr,
  input  wire logic [`SQ_DW-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [`SQ_DW-1:0]         reg_rdata,
  input  wire logic                 lp_mode,
  input  wire logic                 cmp_in,
  output logic [`SQ_NCH-1:0]        sw_sel,
  output logic                      sh_sample,
  output logic [`SQ_RES_W-1:0]      dac_code,
  output logic [1:0]                ref_sel,
  output logic                      ts_bias_en,
  output logic                      range_irq,
  output logic                      scan_done,
  output logic                      busy
);
  localparam int DIV_MIN = (`SQ_SYS_CLK_KHZ + `SQ_CONV_MAX_KHZ - 1) / `SQ_CONV_MAX_KHZ;
  localparam int RW      = $bits(sq_result_s);

  // software registers
  logic [`SQ_CTRL_W-1:0]     ctrl_ff;
  logic [`SQ_CFG_W-1:0]      cfg_ff;
  logic [15:0]               chen_ff;
  logic [`SQ_NCH-1:0]        limen_ff;
  logic [`SQ_RES_W-1:0]      low_ff;
  logic [`SQ_RES_W-1:0]      high_ff;
  logic [`SQ_SAMP_W-1:0]     samp_ff [`SQ_NSAMP];
  logic [31:0]               chsamp_ff;
  // sequencer and converter state
  sq_state_e                 state_ff;
  logic [`SQ_CH_W-1:0]       chan_ff;
  logic [`SQ_SAMP_W-1:0]     cnt_ff;
  logic [`SQ_RES_W-1:0]      mask_ff;
  logic [`SQ_RES_W-1:0]      dac_ff;
  logic [`SQ_RES_W-1:0]      conv_ff;
  logic [`SQ_RES_W-1:0]      res_ff [`SQ_NCH];
  logic [`SQ_NCH-1:0]        range_ff;
  logic                      done_ff;
  logic                      done_pulse_ff;
  logic [3:0]                div_ff;
  logic [`SQ_NCH-1:0]        sw_ff;
  logic                      ts_ff;
  logic [`SQ_DW-1:0]         rdata_ff;

  // bus decode
  wire wr_ctrl   = reg_wr & (reg_addr == `SQ_A_CTRL);
  wire wr_cfg    = reg_wr & (reg_addr == `SQ_A_CFG);
  wire wr_chen   = reg_wr & (reg_addr == `SQ_A_CHEN);
  wire wr_limen  = reg_wr & (reg_addr == `SQ_A_LIMEN);
  wire wr_low    = reg_wr & (reg_addr == `SQ_A_LOW);
  wire wr_high   = reg_wr & (reg_addr == `SQ_A_HIGH);
  wire wr_stat   = reg_wr & (reg_addr == `SQ_A_STAT);
  wire wr_range  = reg_wr & (reg_addr == `SQ_A_RANGE);
  wire wr_chsamp = reg_wr & (reg_addr == `SQ_A_CHSAMP);
  wire rd_fifo   = reg_rd & (reg_addr == `SQ_A_FIFO);
  wire [`SQ_AW-1:0] res_off = reg_addr - `SQ_A_RES0;
  wire              res_hit = (reg_addr >= `SQ_A_RES0) && (res_off < `SQ_AW'(`SQ_NCH));

  // control fields as of this cycle, so a start write sees the enable and mode it carries
  wire [`SQ_CTRL_W-1:0] ctrl_now = wr_ctrl ? reg_wdata[`SQ_CTRL_W-1:0] : ctrl_ff;
  wire       en       = ctrl_now[`SQ_CTRL_EN];
  wire       cont     = ctrl_now[`SQ_CTRL_CONT];
  wire       fw_mode  = ctrl_now[`SQ_CTRL_FW];
  wire       ext16    = ctrl_now[`SQ_CTRL_EXT16];
  wire       temp_en  = ctrl_now[`SQ_CTRL_TEMP];
  wire       ts_auto  = ctrl_now[`SQ_CTRL_TSAUTO];
  wire       ts_off   = ctrl_now[`SQ_CTRL_TSOFF];
  wire       start    = wr_ctrl & reg_wdata[`SQ_CTRL_START] & reg_wdata[`SQ_CTRL_EN];
  wire [3:0] div_sel  = cfg_ff[`SQ_CFG_DIV_LO +: 4];
  wire [`SQ_CH_W-1:0] fw_ch = cfg_ff[`SQ_CFG_FWCH_LO +: `SQ_CH_W];
  wire [1:0] tsamp    = cfg_ff[`SQ_CFG_TSAMP_LO +: 2];
  // low-power modes take the fast clock away, so the sequencer and converter idle
  wire       run      = en & ~lp_mode; // [RQ13]

  // conversion clock: sys_clk divided by div_sel+1, never above the 18 MHz bound
  wire [3:0] div_top  = (div_sel < 4'(DIV_MIN - 1)) ? 4'(DIV_MIN - 1) : div_sel; // [RQ1]
  wire       tick     = run & (div_ff == div_top); // [RQ1]

  // channels taking part in a scan; upper eight only with the extension bit
  wire [`SQ_NCH-1:0] avail = {temp_en, ext16 ? chen_ff[15:8] : 8'h00, chen_ff[7:0]}; // [RQ5] [RQ12]

  function automatic sq_pick_s pick(input logic [`SQ_NCH-1:0] m, input logic [5:0] from);
    sq_pick_s r;
    r = '0;
    for (int i = `SQ_NCH - 1; i >= 0; i--) begin
      if (m[i] && (6'(i) >= from)) begin
        r.found = 1'b1;
        r.idx   = `SQ_CH_W'(i);
      end
    end
    return r;
  endfunction : pick

  wire sq_pick_s first_ch = pick(avail, 6'h00);
  wire sq_pick_s next_ch  = pick(avail, 6'({1'b0, chan_ff}) + 6'h01); // [RQ6]
  wire [`SQ_CH_W-1:0] fw_sel = (fw_ch < `SQ_CH_W'(`SQ_NCH)) ? fw_ch : `SQ_TEMP_CH; // [RQ7]

  // sample length for a channel: its own selector picks one of four programmable times
  function automatic logic [`SQ_SAMP_W-1:0] samp_len(input logic [`SQ_CH_W-1:0] ch);
    logic [1:0]              s;
    logic [`SQ_SAMP_W-1:0]   v;
    s = (ch == `SQ_TEMP_CH) ? tsamp : chsamp_ff[{ch[3:0], 1'b0} +: 2]; // [RQ9]
    v = samp_ff[s]; // [RQ4]
    // short apertures are stretched so sample + 12 bit steps >= 18 ticks
    return (v < `SQ_MIN_SAMPLE) ? `SQ_MIN_SAMPLE : v; // [RQ2]
  endfunction : samp_len

  // result fifo: a full fifo stalls the sequencer in the store state
  sq_result_s fifo_in;
  sq_result_s fifo_out;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  wire        storing    = (state_ff == SQ_STORE);
  wire        store_fire = storing & fifo_in_ready & run;
  assign fifo_in = '{chan: chan_ff, data: conv_ff};

  sq_fifo #(
    .W     (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (store_fire),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (rd_fifo),
    .out_data  (fifo_out)
  );

  // limit check on the finished result
  wire out_of_range = (conv_ff < low_ff) || (conv_ff > high_ff); // [RQ10]
  wire [`SQ_NCH-1:0] range_set = (store_fire & out_of_range & limen_ff[chan_ff])
                                 ? (`SQ_NCH'(1) << chan_ff) : '0; // [RQ11] [RQ16]
  wire [`SQ_NCH-1:0] range_clr = wr_range ? reg_wdata[`SQ_NCH-1:0] : '0;
  wire               scan_end  = store_fire & (fw_mode | ~next_ch.found);
  wire               done_clr  = wr_stat & reg_wdata[`SQ_STAT_DONE];

  // successive approximation step
  wire [`SQ_RES_W-1:0] sar_base = cmp_in ? dac_ff : (dac_ff & ~mask_ff);

  // next state
  sq_state_e           nxt_state;
  logic [`SQ_CH_W-1:0] nxt_chan;
  always_comb begin
    nxt_state = state_ff;
    nxt_chan  = chan_ff;
    if (!run) begin
      nxt_state = SQ_IDLE;
    end else begin
      unique case (state_ff)
        SQ_IDLE: begin
          if (start && fw_mode) begin
            nxt_state = SQ_SAMPLE; // [RQ7]
            nxt_chan  = fw_sel;
          end else if (start && first_ch.found) begin
            nxt_state = SQ_SAMPLE;
            nxt_chan  = first_ch.idx;
          end
        end
        SQ_SAMPLE: begin
          if (tick && cnt_ff == `SQ_SAMP_W'(1)) nxt_state = SQ_CONVERT;
        end
        SQ_CONVERT: begin
          if (tick && mask_ff[0]) nxt_state = SQ_STORE;
        end
        SQ_STORE: begin
          if (fifo_in_ready) begin
            // the next channel samples right away: no switching gap
            if (fw_mode) begin
              nxt_state = cont ? SQ_SAMPLE : SQ_IDLE; // [RQ7] [RQ17]
              nxt_chan  = fw_sel;
            end else if (next_ch.found) begin
              nxt_state = SQ_SAMPLE; // [RQ6]
              nxt_chan  = next_ch.idx;
            end else if (cont && first_ch.found) begin
              nxt_state = SQ_SAMPLE; // [RQ17]
              nxt_chan  = first_ch.idx;
            end else begin
              nxt_state = SQ_IDLE; // [RQ17]
            end
          end
        end
      endcase
    end
  end

  wire entering_sample = (nxt_state == SQ_SAMPLE) && (state_ff != SQ_SAMPLE);
  wire [`SQ_NCH-1:0] nxt_sw = (nxt_state != SQ_IDLE) ? (`SQ_NCH'(1) << nxt_chan) : '0;
  wire nxt_ts = ~ts_off & (~ts_auto | ((nxt_state != SQ_IDLE) && nxt_chan == `SQ_TEMP_CH));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= SQ_IDLE;
      chan_ff  <= '0;
      sw_ff    <= '0;
      ts_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      chan_ff  <= nxt_chan;
      sw_ff    <= nxt_sw; // [RQ14]
      ts_ff    <= nxt_ts; // [RQ15]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
    end else if (!run || entering_sample || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // aperture counter and sar registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      mask_ff <= '0;
      dac_ff  <= '0;
      conv_ff <= '0;
    end else if (entering_sample) begin
      cnt_ff <= samp_len(nxt_chan); // [RQ9]
    end else if (tick && state_ff == SQ_SAMPLE) begin
      cnt_ff  <= cnt_ff - `SQ_SAMP_W'(1);
      mask_ff <= `SQ_MSB_MASK;
      dac_ff  <= `SQ_MSB_MASK;
    end else if (tick && state_ff == SQ_CONVERT) begin
      mask_ff <= mask_ff >> 1;
      dac_ff  <= sar_base | (mask_ff >> 1);
      if (mask_ff[0]) conv_ff <= sar_base; // [RQ2]
    end
  end

  // one result register per channel
  for (genvar g = 0; g < `SQ_NCH; g++) begin : g_res
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        res_ff[g] <= '0;
      end else if (store_fire && chan_ff == `SQ_CH_W'(g)) begin
        res_ff[g] <= conv_ff; // [RQ8]
      end
    end
  end

  // sticky flags: a hardware set in the clearing cycle survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      range_ff      <= '0;
      done_ff       <= 1'b0;
      done_pulse_ff <= 1'b0;
    end else begin
      range_ff      <= (range_ff & ~range_clr) | range_set; // [RQ16]
      done_ff       <= (done_ff & ~done_clr) | scan_end; // [RQ17]
      done_pulse_ff <= scan_end; // [RQ17]
    end
  end

  // software registers; start is a write-only pulse and is not stored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= `SQ_RST_CTRL;
      cfg_ff    <= `SQ_RST_CFG;
      chen_ff   <= `SQ_RST_CHEN;
      limen_ff  <= '0;
      low_ff    <= `SQ_RST_LOW;
      high_ff   <= `SQ_RST_HIGH;
      chsamp_ff <= '0;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata[`SQ_CTRL_W-1:0] & ~(`SQ_CTRL_W'(1) << `SQ_CTRL_START);
      if (wr_cfg) cfg_ff <= reg_wdata[`SQ_CFG_W-1:0]; // [RQ3]
      if (wr_chen) chen_ff <= reg_wdata[15:0]; // [RQ5]
      if (wr_limen) limen_ff <= reg_wdata[`SQ_NCH-1:0]; // [RQ16]
      if (wr_low) low_ff <= reg_wdata[`SQ_RES_W-1:0]; // [RQ10]
      if (wr_high) high_ff <= reg_wdata[`SQ_RES_W-1:0]; // [RQ10]
      if (wr_chsamp) chsamp_ff <= reg_wdata; // [RQ9]
    end
  end

  for (genvar s = 0; s < `SQ_NSAMP; s++) begin : g_samp
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        samp_ff[s] <= `SQ_RST_SAMP;
      end else if (reg_wr && reg_addr == `SQ_A_SAMP0 + `SQ_AW'(s)) begin
        samp_ff[s] <= reg_wdata[`SQ_SAMP_W-1:0]; // [RQ4]
      end
    end
  end
  // read mux; unmapped addresses answer zero
  logic [`SQ_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (res_hit) begin
      rd_mux = `SQ_DW'(res_ff[res_off[`SQ_CH_W-1:0]]); // [RQ8]
    end else begin
      case (reg_addr)
        `SQ_A_CTRL:   rd_mux = `SQ_DW'(ctrl_ff);
        `SQ_A_CFG:    rd_mux = `SQ_DW'(cfg_ff);
        `SQ_A_CHEN:   rd_mux = `SQ_DW'(chen_ff);
        `SQ_A_LIMEN:  rd_mux = `SQ_DW'(limen_ff);
        `SQ_A_LOW:    rd_mux = `SQ_DW'(low_ff);
        `SQ_A_HIGH:   rd_mux = `SQ_DW'(high_ff);
        `SQ_A_STAT:   rd_mux = `SQ_DW'({lp_mode, fifo_out_valid, done_ff, busy});
        `SQ_A_RANGE:  rd_mux = `SQ_DW'(range_ff);
        `SQ_A_CHSAMP: rd_mux = chsamp_ff;
        `SQ_A_FIFO: begin
          rd_mux[`SQ_FIFO_VALID]                   = fifo_out_valid;
          rd_mux[`SQ_FIFO_CH_LO +: `SQ_CH_W]       = fifo_out_valid ? fifo_out.chan : '0;
          rd_mux[`SQ_RES_W-1:0]                    = fifo_out_valid ? fifo_out.data : '0;
        end
        default: begin
          if (reg_addr >= `SQ_A_SAMP0 && reg_addr < `SQ_A_SAMP0 + `SQ_AW'(`SQ_NSAMP)) begin
            rd_mux = `SQ_DW'(samp_ff[reg_addr[1:0]]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign sw_sel     = sw_ff; // [RQ14]
  assign sh_sample  = (state_ff == SQ_SAMPLE); // [RQ4]
  assign dac_code   = dac_ff;
  assign ref_sel    = cfg_ff[`SQ_CFG_REF_LO +: 2]; // [RQ3]
  assign ts_bias_en = ts_ff; // [RQ15]
  assign range_irq  = |range_ff; // [RQ10]
  assign scan_done  = done_pulse_ff;
  assign busy       = (state_ff != SQ_IDLE);

endmodule : sq_adc_seq
`default_nettype wire

// >>> design/sq_consts.svh
// register map, field positions, reset values and timing figures of the converter sequencer
// included by the package and the design file; definitions only
`ifndef SQ_CONSTS_SVH
`define SQ_CONSTS_SVH

`define SQ_AW            6
`define SQ_DW            32
`define SQ_RES_W         12
`define SQ_CH_W          5
`define SQ_NCH           17
`define SQ_TEMP_CH       5'h10
`define SQ_BASE_CH       8
`define SQ_SAMP_W        8
`define SQ_NSAMP         4

`define SQ_A_CTRL        6'h00
`define SQ_A_CFG         6'h01
`define SQ_A_CHEN        6'h02
`define SQ_A_LIMEN       6'h03
`define SQ_A_LOW         6'h04
`define SQ_A_HIGH        6'h05
`define SQ_A_STAT        6'h06
`define SQ_A_RANGE       6'h07
`define SQ_A_SAMP0       6'h08
`define SQ_A_CHSAMP      6'h0c
`define SQ_A_FIFO        6'h0e
`define SQ_A_RES0        6'h10

`define SQ_CTRL_EN       0
`define SQ_CTRL_START    1
`define SQ_CTRL_CONT     2
`define SQ_CTRL_FW       3
`define SQ_CTRL_EXT16    4
`define SQ_CTRL_TEMP     5
`define SQ_CTRL_TSAUTO   6
`define SQ_CTRL_TSOFF    7
`define SQ_CTRL_W        8

`define SQ_CFG_REF_LO    0
`define SQ_CFG_DIV_LO    2
`define SQ_CFG_FWCH_LO   6
`define SQ_CFG_TSAMP_LO  11
`define SQ_CFG_W         13

`define SQ_STAT_BUSY     0
`define SQ_STAT_DONE     1
`define SQ_STAT_FIFOV    2
`define SQ_STAT_LP       3
`define SQ_FIFO_VALID    31
`define SQ_FIFO_CH_LO    16

`define SQ_RST_CTRL      8'h00
`define SQ_RST_CFG       13'h0000
`define SQ_RST_CHEN      16'h00ff
`define SQ_RST_LOW       12'h000
`define SQ_RST_HIGH      12'hfff
`define SQ_RST_SAMP      8'h06
`define SQ_MIN_SAMPLE    8'h06
`define SQ_MSB_MASK      12'h800

`define SQ_SYS_CLK_KHZ   10000
`define SQ_CONV_MAX_KHZ  18000

`endif

// >>> design/sq_pkg.sv
// types shared by the converter sequencer design
// relies on sq_consts.svh for widths
`include "sq_consts.svh"

package sq_pkg;

  typedef enum logic [1:0] {
    SQ_IDLE    = 2'b00,
    SQ_SAMPLE  = 2'b01,
    SQ_CONVERT = 2'b10,
    SQ_STORE   = 2'b11
  } sq_state_e;

  typedef struct packed {
    logic [`SQ_CH_W-1:0]  chan;
    logic [`SQ_RES_W-1:0] data;
  } sq_result_s;

  typedef struct packed {
    logic                 found;
    logic [`SQ_CH_W-1:0]  idx;
  } sq_pick_s;

endpackage : sq_pkg

// >>> dv/sq_adc_seq_asserts.sv
// checker: port timing relations of the converter sequencer
// bound into sq_adc_seq; sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "sq_consts.svh"

module sq_adc_seq_chk
  import sq_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic [`SQ_AW-1:0]    reg_addr,
  input wire logic [`SQ_DW-1:0]    reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [`SQ_DW-1:0]    reg_rdata,
  input wire logic                 lp_mode,
  input wire logic                 cmp_in,
  input wire logic [`SQ_NCH-1:0]   sw_sel,
  input wire logic                 sh_sample,
  input wire logic [`SQ_RES_W-1:0] dac_code,
  input wire logic [1:0]           ref_sel,
  input wire logic                 ts_bias_en,
  input wire logic                 range_irq,
  input wire logic                 scan_done,
  input wire logic                 busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // six ticks is the shortest aperture; 12 trials follow, of which the check demands eight cycles
  sequence s_aperture;
    sh_sample [*6];
  endsequence
  sequence s_trials;
    (!sh_sample && busy) [*8];
  endsequence

  // low-power aborts are exempt: they cut both phases short on purpose
  chk_aperture_min: assert property (disable iff (rst || lp_mode)
    $rose(sh_sample) |-> s_aperture) else $error("sample aperture too short");
  chk_trial_span: assert property (disable iff (rst || lp_mode)
    $fell(sh_sample) && busy |-> s_trials) else $error("conversion phase too short");
  chk_first_trial: assert property ($fell(sh_sample) && busy |-> dac_code == `SQ_MSB_MASK)
    else $error("first trial code is not the midscale");
  chk_sample_switch: assert property (sh_sample |-> busy && $onehot(sw_sel))
    else $error("sampling without exactly one switch closed");
  chk_switch_onehot: assert property ($onehot0(sw_sel))
    else $error("more than one analog switch closed");
  chk_lowpower_stop: assert property (lp_mode |=> !busy && !sh_sample)
    else $error("converter still running in low-power mode");
  chk_done_pulse: assert property (scan_done |=> !scan_done)
    else $error("scan done longer than one cycle");
  chk_done_after: assert property (scan_done |-> $past(busy))
    else $error("scan done without a preceding conversion");
  chk_range_sticky: assert property (
    range_irq && !(reg_wr && reg_addr == `SQ_A_RANGE) |=> range_irq)
    else $error("range flag dropped without a clear");
  chk_range_rise: assert property ($rose(range_irq) |-> $past(busy))
    else $error("range flag raised outside a conversion");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside the read answer cycle");
endmodule : sq_adc_seq_chk

bind sq_adc_seq sq_adc_seq_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_sq_adc_seq_chk (
  .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lp_mode, .cmp_in,
  .sw_sel, .sh_sample, .dac_code, .ref_sel, .ts_bias_en, .range_irq, .scan_done, .busy
);
`default_nettype wire

// >>> dv/sq_afe_model.sv
// model of the analog side: input switches, sample-and-hold, comparator
// inputs in vin are set by the bench; compares the held level to dac_code
`timescale 1ns/1ps
`default_nettype none
`include "sq_consts.svh"

module sq_afe_model
  import sq_pkg::*;
(
  input wire logic                                 sys_clk,
  input wire logic                                 rst,
  input wire logic [`SQ_NCH-1:0]                   sw_sel,
  input wire logic                                 sh_sample,
  input wire logic [`SQ_RES_W-1:0]                 dac_code,
  input wire logic [`SQ_NCH-1:0][`SQ_RES_W-1:0]    vin,
  output logic                                     cmp_in
);
  logic [`SQ_RES_W-1:0] held_ff;
  logic                 held_ok_ff;
  logic                 toggle_ff;
  logic [`SQ_CH_W-1:0]  pick;

  always_comb begin
    pick = '0;
    for (int i = 0; i < `SQ_NCH; i++) begin
      if (sw_sel[i]) pick = i[`SQ_CH_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      held_ff    <= '0;
      held_ok_ff <= 1'b0;
      toggle_ff  <= 1'b0;
    end else begin
      toggle_ff <= !toggle_ff;
      if (sh_sample) begin
        held_ff    <= vin[pick];
        held_ok_ff <= $onehot(sw_sel);
      end
    end
  end

  // no valid held level means a restless output, so a missed sample cannot pass by luck
  assign cmp_in = (held_ok_ff && !sh_sample) ? (held_ff >= dac_code) : toggle_ff;
endmodule : sq_afe_model
`default_nettype wire

// >>> dv/tb_sq_adc_seq.sv
// testbench: register-level scenarios for the converter sequencer
// sq_adc_seq faces sq_afe_model; register master runs from this module
`timescale 1ns/1ps
`default_nettype none
`include "sq_consts.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_sq_adc_seq;
  logic                              sys_clk, rst, reg_wr, reg_rd, lp_mode, cmp_in;
  logic                              sh_sample, ts_bias_en, range_irq, scan_done, busy, irq_busy;
  logic [`SQ_AW-1:0]                 reg_addr;
  logic [`SQ_DW-1:0]                 reg_wdata, reg_rdata, d;
  logic [`SQ_NCH-1:0]                sw_sel, sel_seen;
  logic [`SQ_RES_W-1:0]              dac_code;
  logic [1:0]                        ref_sel;
  logic [`SQ_NCH-1:0][`SQ_RES_W-1:0] vin;
  int                                mismatches, tests_run, cyc, n, dones;

  sq_adc_seq #(.FIFO_DEPTH(8)) i_sq_adc_seq (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lp_mode, .cmp_in,
    .sw_sel, .sh_sample, .dac_code, .ref_sel, .ts_bias_en, .range_irq, .scan_done, .busy
  );
  sq_afe_model i_sq_afe_model (.sys_clk, .rst, .sw_sel, .sh_sample, .dac_code, .vin, .cmp_in);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // a hang shows up here at cycle 8000, more than ten times the cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic wr(input logic [`SQ_AW-1:0] a, input logic [`SQ_DW-1:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [`SQ_AW-1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic chk_rd(input string nm, input logic [`SQ_AW-1:0] a, input logic [`SQ_DW-1:0] e);
    rd(a);
    `CHK(nm, e, d);
  endtask : chk_rd

  // start with ctrl, then follow the run until idle
  task automatic run_scan(input logic [`SQ_DW-1:0] ctrl);
    wr(`SQ_A_CTRL, ctrl);
    n = 0;
    dones = 0;
    irq_busy = 1'b0;
    sel_seen = '0;
    #1;
    while (busy === 1'b1 && n < 2000) begin
      n++;
      sel_seen |= sw_sel;
      if (range_irq === 1'b1) irq_busy = 1'b1;
      @(posedge sys_clk);
      #1;
      if (scan_done === 1'b1) dones++;
    end
  endtask : run_scan

  task automatic t_reset;
    chk_rd("ctrl", `SQ_A_CTRL, 32'h0);
    chk_rd("chen", `SQ_A_CHEN, 32'h0000_00ff);
    chk_rd("low", `SQ_A_LOW, 32'h0);
    chk_rd("high", `SQ_A_HIGH, 32'h0000_0fff);
    for (int i = 0; i < 4; i++) chk_rd("samp", `SQ_A_SAMP0 + 6'(i), 32'h6);
    chk_rd("unmapped", 6'h3f, 32'h0);
    `CHK("bias", 1'b1, ts_bias_en);
  endtask : t_reset

  // continuous scan of eight channels fills the buffer; the next store must wait
  task automatic t_fifo_cont;
    dones = 0;
    wr(`SQ_A_CTRL, 32'h07);
    repeat (400) begin
      @(posedge sys_clk);
      #1;
      if (scan_done === 1'b1) dones++;
    end
    `CHK("done count", 1, dones);
    `CHK("stalled busy", 1'b1, busy);
    chk_rd("stat full", `SQ_A_STAT, 32'h7);
    wr(`SQ_A_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(`SQ_A_FIFO);
      `CHK("fifo word", {1'b1, 5'(i), vin[i]}, {d[31], d[20:16], d[11:0]});
    end
    rd(`SQ_A_FIFO);
    `CHK("fifo empty", 1'b0, d[31]);
    wr(`SQ_A_STAT, 32'h2);
    chk_rd("stat clear", `SQ_A_STAT, 32'h0);
  endtask : t_fifo_cont

  task automatic t_scan;
    wr(`SQ_A_CHEN, 32'h3);
    wr(`SQ_A_SAMP0 + 6'h1, 32'h0a);
    wr(`SQ_A_CHSAMP, 32'h4);
    wr(`SQ_A_LOW, 32'h0b0);
    wr(`SQ_A_HIGH, 32'h150);
    wr(`SQ_A_LIMEN, 32'h1);
    run_scan(32'h03);
    `CHK("scan cycles", 42, n);
    `CHK("scan switches", 17'h3, sel_seen);
    `CHK("early range", 1'b1, irq_busy);
    `CHK("done pulses", 1, dones);
    chk_rd("res0", `SQ_A_RES0, {20'h0, vin[0]});
    chk_rd("res1", `SQ_A_RES0 + 6'h1, {20'h0, vin[1]});
    chk_rd("range", `SQ_A_RANGE, 32'h1);
    wr(`SQ_A_RANGE, 32'h1);
    @(posedge sys_clk);
    #1;
    `CHK("irq clear", 1'b0, range_irq);
  endtask : t_scan

  task automatic t_ext16;
    wr(`SQ_A_CHEN, 32'h8000);
    run_scan(32'h33);
    `CHK("ext cycles", 38, n);
    `CHK("ext switches", 17'h18000, sel_seen);
    chk_rd("res15", `SQ_A_RES0 + 6'h0f, {20'h0, vin[15]});
    chk_rd("res16", `SQ_A_RES0 + 6'h10, {20'h0, vin[16]});
  endtask : t_ext16

  task automatic t_fw;
    wr(`SQ_A_CFG, 32'hc4);
    run_scan(32'h0b);
    `CHK("fw cycles", 37, n);
    `CHK("fw switch", 17'h8, sel_seen);
    chk_rd("res3", `SQ_A_RES0 + 6'h3, {20'h0, vin[3]});
  endtask : t_fw

  task automatic t_ref;
    for (int r = 0; r < 4; r++) begin
      wr(`SQ_A_CFG, 32'(r));
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("ref", 2'(r), ref_sel);
    end
  endtask : t_ref

  task automatic t_lp;
    wr(`SQ_A_CHEN, 32'h1);
    wr(`SQ_A_CTRL, 32'h03);
    repeat (3) @(posedge sys_clk);
    lp_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("lp abort", 1'b0, busy);
    chk_rd("lp stat", `SQ_A_STAT, 32'he);
    wr(`SQ_A_CTRL, 32'h03);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("lp refuse", 1'b0, busy);
    lp_mode <= 1'b0;
  endtask : t_lp

  task automatic t_bias;
    logic [`SQ_DW-1:0] ctl [3] = '{32'h80, 32'h40, 32'h0};
    logic              exp [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wr(`SQ_A_CTRL, ctl[i]);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("bias", exp[i], ts_bias_en);
    end
  endtask : t_bias

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    lp_mode = 1'b0;
    for (int i = 0; i < `SQ_NCH; i++) vin[i] = 12'h0a5 + 12'(i) * 12'h0f1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_fifo_cont();
    t_scan();
    t_ext16();
    t_fw();
    t_ref();
    t_lp();
    t_bias();
    test_done();
  end
endmodule : tb_sq_adc_seq
`default_nettype wire
